// ---- hdl/fpi_defs.svh ----
// Purpose: Constants of the fieldbus process image
// Assumes: 16-bit word-addressed register port
// Notes:   Offsets are word addresses
`ifndef FPI_DEFS_SVH
`define FPI_DEFS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define FPI_CLK_PERIOD_NS 5
`define FPI_SECOND_NS 1000000000

// ----------------------------------------
// Word map
// ----------------------------------------
`define FPI_ADDR_W 8
`define FPI_OUTSTAT_BASE 8'h00
`define FPI_OUTSTAT_WORDS 6
`define FPI_VIO_BASE 8'h08
`define FPI_VIO_WORDS 4
`define FPI_REARM_ADDR 8'h0c
`define FPI_CODE_ADDR 8'h0d
`define FPI_REARM_FB_ADDR 8'h0e
`define FPI_CODE_FB_ADDR 8'h0f
`define FPI_CTRL_ADDR 8'h10
`define FPI_FLOG_BASE 8'h20
`define FPI_FLOG_WORDS 150
`define FPI_SINFO_BASE 8'hc0
`define FPI_SINFO_WORDS 30

// ----------------------------------------
// Control fields and reset values
// ----------------------------------------
`define FPI_CTRL_FLOG_BIT 0
`define FPI_CTRL_SINFO_BIT 1
`define FPI_CTRL_RESET 2'h0

// ----------------------------------------
// Fault log layout
// ----------------------------------------
`define FPI_FLOG_ENTRIES 10
`define FPI_FLOG_ENTRY_WORDS 15
`define FPI_FLOG_W_TS 0
`define FPI_FLOG_W_LEN 2
`define FPI_FLOG_W_NAME 4
`define FPI_FLOG_NAME_WORDS 6
`define FPI_FLOG_W_ERR 10
`define FPI_FLOG_W_ADV 11
`define FPI_FLOG_W_IDX 12
`define FPI_MSG_SCALE 16'h0064

// ----------------------------------------
// System information layout
// ----------------------------------------
`define FPI_SI_W_SEC 0
`define FPI_SI_W_MODE 2
`define FPI_SI_W_LEN 3
`define FPI_SI_W_NAME 5
`define FPI_SI_NAME_WORDS 8
`define FPI_SI_W_CRC 13

// ----------------------------------------
// Operating mode codes
// ----------------------------------------
`define FPI_MODE_NORMAL 16'h0001
`define FPI_MODE_CONFIG 16'h0002
`define FPI_MODE_LOCKOUT 16'h0004
`define FPI_MODE_AWAIT_RESET 16'h0041
`define FPI_MODE_ENTER_CONFIG 16'h0081

`endif

// ---- hdl/fpi_pkg.sv ----
// Purpose: Types of the fieldbus process image
// Assumes: Included constants from fpi_defs.svh
// Notes:   Types only
`include "fpi_defs.svh"
package fpi_pkg;

    // ----------------------------------------
    // Operating state of the controller
    // ----------------------------------------
    typedef enum logic [2:0] {
        FPI_ST_NORMAL,
        FPI_ST_CONFIG,
        FPI_ST_LOCKOUT,
        FPI_ST_AWAIT_RESET,
        FPI_ST_ENTER_CONFIG
    } fpi_opstate_t;

    // ----------------------------------------
    // Fault as reported by the controller core
    // ----------------------------------------
    typedef struct packed {
        logic [95:0] name;
        logic [15:0] errCode;
        logic [15:0] advCode;
    } fpi_fault_t;

    // ----------------------------------------
    // Stored fault log entry
    // ----------------------------------------
    typedef struct packed {
        logic [31:0] timestamp;
        logic [31:0] nameLen;
        logic [95:0] name;
        logic [15:0] errCode;
        logic [15:0] advCode;
        logic [15:0] msgIndex;
    } fpi_log_entry_t;

    // ----------------------------------------
    // Register port request
    // ----------------------------------------
    typedef struct packed {
        logic wrStb;
        logic rdStb;
        logic [7:0] addr;
        logic [15:0] wrData;
    } fpi_req_t;

endpackage

// ---- hdl/fpi_seconds_counter.sv ----
// Purpose: Seconds since power-up with a one-second tick
// Assumes: sys_clk at 200 MHz
// Notes:   Tick count is a parameter so simulation can shorten it
`timescale 1ns/10ps
`include "fpi_defs.svh"
module fpi_seconds_counter #(
    parameter int TICKS_PER_SEC = `FPI_SECOND_NS / `FPI_CLK_PERIOD_NS
) (
    input wire logic sys_clk,
    input wire logic resetn,
    output logic [31:0] seconds
);

    // ----------------------------------------
    // Prescaler
    // ----------------------------------------
    logic [31:0] presc_ff;
    logic [31:0] secs_ff;
    logic [31:0] nxt_presc;
    logic [31:0] nxt_secs;
    wire logic secTick = (presc_ff == 32'(TICKS_PER_SEC - 1));

    assign nxt_presc = secTick ? 32'h0 : presc_ff + 32'h1;
    // Wraps after 136 years, no saturation needed
    assign nxt_secs = secTick ? secs_ff + 32'h1 : secs_ff;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            presc_ff <= 32'h0;
            secs_ff <= 32'h0;
        end else begin
            presc_ff <= nxt_presc;
            secs_ff <= nxt_secs;
        end
    end

    assign seconds = secs_ff;

endmodule // fpi_seconds_counter

// ---- hdl/fpi_process_image.sv ----
// Purpose: Cyclic process image between safety core and fieldbus master
// Assumes: Register port driven by the fieldbus slave, 16-bit words
// Notes:   Reset is taken as power-up for the seconds counters
//
// Summary of operation
// [R1] 96 output status bits readable in three 4-byte slots, no write data.
// [R2] Master writes 64 virtual inputs, each used as on/off or silence permit.
// [R3] Master writes 16 rearm bits, used only by the rearm/skip-delay sequence.
// [R4] Master supplies a 16-bit actuation code with the rearm sequence.
// [R5] Device returns one feedback bit per rearm bit, two bytes.
// [R6] Device returns the actuation code as a 16-bit feedback word.
// [R7] Fault log has ten 15-word entries, newest first, oldest last.
// [R8] Entry order: timestamp, name length, name, error, advanced, index, reserved.
// [R9] Fault timestamp is seconds since power-up at the fault.
// [R10] Fault name length counts ASCII characters in the fault name.
// [R11] Fault code is error code dot advanced error code.
// [R12] Message index equals error code times 100 plus advanced code.
// [R13] System information is one 30-word read-only buffer.
// [R14] Buffer: seconds, mode, config name length, config name, config CRC.
// [R15] Mode codes: 1 normal, 2 config, 4 lockout, 65 await reset, 129 entering.
// [R16] Config name length counts ASCII characters in the config name.
// [R17] Config CRC field shows CRC of the configuration in force.
// [R18] Fault log and system information are off until the master enables them.
// [R19] Lowest-numbered bits in the first byte, ascending through later bytes.
// [R20] Feedback fields echo the last rearm bits and code received.
//
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/10ps
`include "fpi_defs.svh"
module fpi_process_image #(
    parameter int TICKS_PER_SEC = `FPI_SECOND_NS / `FPI_CLK_PERIOD_NS
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire fpi_pkg::fpi_req_t busReq,
    output logic [15:0] rdData,
    input wire logic [95:0] outStatus,
    input wire logic [63:0] silencePermitSel,
    output logic [63:0] onOffBits,
    output logic [63:0] silencePermitBits,
    output logic [15:0] virtualRearmBits,
    output logic [15:0] actuationCode,
    output logic rearmUpdate,
    input wire logic faultValid,
    input wire fpi_pkg::fpi_fault_t faultIn,
    input wire fpi_pkg::fpi_opstate_t opState,
    input wire logic [127:0] configName,
    input wire logic [31:0] configCrc,
    output logic faultLogActive,
    output logic sysInfoActive
);

    // ----------------------------------------
    // Helper functions
    // ----------------------------------------
    // Characters up to the first NUL, bytes taken low first
    function automatic logic [31:0] asciiLen(input logic [127:0] str);
        logic [31:0] n;
        logic stop;
        n = 32'h0;
        stop = 1'b0;
        for (int i = 0; i < 16; i++) begin
            if (str[8*i +: 8] == 8'h00) begin
                stop = 1'b1;
            end else if (!stop) begin
                n = n + 32'h1;
            end
        end
        return n;
    endfunction

    function automatic logic [15:0] msgIndex(input logic [15:0] err, input logic [15:0] adv);
        logic [31:0] prod;
        prod = 32'(err) * 32'(`FPI_MSG_SCALE);
        return prod[15:0] + adv; // R12
    endfunction

    function automatic logic [15:0] modeCode(input fpi_pkg::fpi_opstate_t st);
        logic [15:0] code;
        unique case (st)
            fpi_pkg::FPI_ST_NORMAL: code = `FPI_MODE_NORMAL; // R15
            fpi_pkg::FPI_ST_CONFIG: code = `FPI_MODE_CONFIG; // R15
            fpi_pkg::FPI_ST_LOCKOUT: code = `FPI_MODE_LOCKOUT; // R15
            fpi_pkg::FPI_ST_AWAIT_RESET: code = `FPI_MODE_AWAIT_RESET; // R15
            fpi_pkg::FPI_ST_ENTER_CONFIG: code = `FPI_MODE_ENTER_CONFIG; // R15
            default: code = 16'h0000;
        endcase
        return code;
    endfunction

    // Two 16-bit halves of a 32-bit value, low word first
    function automatic logic [15:0] half(input logic [31:0] v, input logic hi);
        return hi ? v[31:16] : v[15:0];
    endfunction

    // ----------------------------------------
    // Seconds since power-up
    // ----------------------------------------
    logic [31:0] seconds;

    fpi_seconds_counter #(
        .TICKS_PER_SEC(TICKS_PER_SEC)
    ) u_seconds (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .seconds(seconds)
    );

    // ----------------------------------------
    // Write decode
    // ----------------------------------------
    wire logic [7:0] addr = busReq.addr;
    wire logic wrVio = busReq.wrStb && (addr >= `FPI_VIO_BASE)
        && (addr < `FPI_VIO_BASE + 8'(`FPI_VIO_WORDS));
    wire logic [1:0] vioSel = 2'(addr - `FPI_VIO_BASE);
    wire logic wrRearm = busReq.wrStb && (addr == `FPI_REARM_ADDR);
    wire logic wrCode = busReq.wrStb && (addr == `FPI_CODE_ADDR);
    wire logic wrCtrl = busReq.wrStb && (addr == `FPI_CTRL_ADDR);

    logic [63:0] vio_ff;
    logic [15:0] rearm_ff;
    logic [15:0] code_ff;
    logic [15:0] rearmFb_ff;
    logic [15:0] codeFb_ff;
    logic [1:0] ctrl_ff;
    logic rearmUpd_ff;
    logic [63:0] onOff_ff;
    logic [63:0] permit_ff;
    logic [63:0] nxt_vio;

    // Word k of the slot carries bits 16k+15..16k, low byte first
    always_comb begin
        nxt_vio = vio_ff;
        if (wrVio) begin
            nxt_vio[16*vioSel +: 16] = busReq.wrData; // R2 R19
        end
    end

    // Read-only slots ignore writes, so no decode for them
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            vio_ff <= 64'h0;
            rearm_ff <= 16'h0;
            code_ff <= 16'h0;
            ctrl_ff <= `FPI_CTRL_RESET; // R18
            rearmUpd_ff <= 1'b0;
        end else begin
            vio_ff <= nxt_vio;
            rearm_ff <= wrRearm ? busReq.wrData : rearm_ff; // R3
            code_ff <= wrCode ? busReq.wrData : code_ff; // R4
            ctrl_ff <= wrCtrl ? busReq.wrData[1:0] : ctrl_ff; // R18
            rearmUpd_ff <= wrRearm || wrCode;
        end
    end

    // ----------------------------------------
    // Virtual input routing and feedback
    // ----------------------------------------
    // Feedback lags the stored value one cycle, the sequence sees the stored value undelayed
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            onOff_ff <= 64'h0;
            permit_ff <= 64'h0;
            rearmFb_ff <= 16'h0;
            codeFb_ff <= 16'h0;
        end else begin
            onOff_ff <= vio_ff & ~silencePermitSel; // R2
            permit_ff <= vio_ff & silencePermitSel; // R2
            rearmFb_ff <= rearm_ff; // R5 R20
            codeFb_ff <= code_ff; // R6 R20
        end
    end

    assign onOffBits = onOff_ff;
    assign silencePermitBits = permit_ff;
    // Only the rearm/skip-delay sequence consumes these
    assign virtualRearmBits = rearm_ff; // R3
    assign actuationCode = code_ff;
    assign rearmUpdate = rearmUpd_ff;
    assign faultLogActive = ctrl_ff[`FPI_CTRL_FLOG_BIT];
    assign sysInfoActive = ctrl_ff[`FPI_CTRL_SINFO_BIT];

    // ----------------------------------------
    // Fault log
    // ----------------------------------------
    // Captured even while not exchanged, so enabling shows history
    fpi_pkg::fpi_log_entry_t flog_ff [`FPI_FLOG_ENTRIES];
    fpi_pkg::fpi_log_entry_t newEntry;

    always_comb begin
        newEntry.timestamp = seconds; // R9
        newEntry.nameLen = asciiLen({32'h0, faultIn.name}); // R10
        newEntry.name = faultIn.name;
        newEntry.errCode = faultIn.errCode; // R11
        newEntry.advCode = faultIn.advCode; // R11
        newEntry.msgIndex = msgIndex(faultIn.errCode, faultIn.advCode); // R12
    end

    // Newest at entry 0, oldest falls out of the last slot
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < `FPI_FLOG_ENTRIES; i++) begin
                flog_ff[i] <= '0;
            end
        end else if (faultValid) begin
            flog_ff[0] <= newEntry; // R7
            for (int i = 1; i < `FPI_FLOG_ENTRIES; i++) begin
                flog_ff[i] <= flog_ff[i-1]; // R7
            end
        end
    end

    wire logic [7:0] flogOff = addr - `FPI_FLOG_BASE;
    wire logic inFlog = (addr >= `FPI_FLOG_BASE)
        && (flogOff < 8'(`FPI_FLOG_WORDS));
    wire logic [3:0] flogEnt = 4'(flogOff / 8'(`FPI_FLOG_ENTRY_WORDS));
    wire logic [3:0] flogWrd = 4'(flogOff % 8'(`FPI_FLOG_ENTRY_WORDS));
    fpi_pkg::fpi_log_entry_t selEntry;
    logic [15:0] flogWord;
    logic [3:0] nameIdx;

    always_comb begin
        selEntry = inFlog ? flog_ff[flogEnt] : '0;
        nameIdx = flogWrd - 4'(`FPI_FLOG_W_NAME);
        flogWord = 16'h0000;
        if (flogWrd < 4'(`FPI_FLOG_W_LEN)) begin
            flogWord = half(selEntry.timestamp, flogWrd[0]); // R8
        end else if (flogWrd < 4'(`FPI_FLOG_W_NAME)) begin
            flogWord = half(selEntry.nameLen, flogWrd[0]); // R8
        end else if (flogWrd < 4'(`FPI_FLOG_W_ERR)) begin
            flogWord = selEntry.name[16*nameIdx +: 16]; // R8
        end else if (flogWrd == 4'(`FPI_FLOG_W_ERR)) begin
            flogWord = selEntry.errCode; // R8
        end else if (flogWrd == 4'(`FPI_FLOG_W_ADV)) begin
            flogWord = selEntry.advCode; // R8
        end else if (flogWrd == 4'(`FPI_FLOG_W_IDX)) begin
            flogWord = selEntry.msgIndex; // R8
        end
    end

    // ----------------------------------------
    // System information buffer
    // ----------------------------------------
    wire logic [7:0] sinfoOff = addr - `FPI_SINFO_BASE;
    wire logic inSinfo = (addr >= `FPI_SINFO_BASE)
        && (sinfoOff < 8'(`FPI_SINFO_WORDS));
    wire logic [31:0] cfgLen = asciiLen(configName); // R16
    wire logic [4:0] sw = 5'(sinfoOff);
    wire logic [4:0] cfgIdx = sw - 5'(`FPI_SI_W_NAME);
    logic [15:0] sinfoWord;

    // Words past the CRC are reserved and read zero
    always_comb begin
        sinfoWord = 16'h0000;
        if (sw < 5'(`FPI_SI_W_MODE)) begin
            sinfoWord = half(seconds, sw[0]); // R14
        end else if (sw == 5'(`FPI_SI_W_MODE)) begin
            sinfoWord = modeCode(opState); // R14 R15
        end else if (sw < 5'(`FPI_SI_W_NAME)) begin
            sinfoWord = half(cfgLen, ~sw[0]); // R14 R16
        end else if (sw < 5'(`FPI_SI_W_CRC)) begin
            sinfoWord = configName[16*cfgIdx[2:0] +: 16]; // R14
        end else if (sw < 5'(`FPI_SI_W_CRC + 2)) begin
            sinfoWord = half(configCrc, ~sw[0]); // R14 R17
        end
    end

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    wire logic inOutStat = (addr < `FPI_OUTSTAT_BASE + 8'(`FPI_OUTSTAT_WORDS));
    wire logic [2:0] osSel = 3'(addr - `FPI_OUTSTAT_BASE);
    wire logic inVio = (addr >= `FPI_VIO_BASE)
        && (addr < `FPI_VIO_BASE + 8'(`FPI_VIO_WORDS));
    logic [15:0] rdMux;
    logic [15:0] rdData_ff;

    // Unmapped words and disabled optional slots read zero
    always_comb begin
        rdMux = 16'h0000;
        if (inOutStat) begin
            rdMux = outStatus[16*osSel +: 16]; // R1 R19
        end else if (inVio) begin
            rdMux = vio_ff[16*vioSel +: 16];
        end else if (addr == `FPI_REARM_ADDR) begin
            rdMux = rearm_ff;
        end else if (addr == `FPI_CODE_ADDR) begin
            rdMux = code_ff;
        end else if (addr == `FPI_REARM_FB_ADDR) begin
            rdMux = rearmFb_ff; // R5
        end else if (addr == `FPI_CODE_FB_ADDR) begin
            rdMux = codeFb_ff; // R6
        end else if (addr == `FPI_CTRL_ADDR) begin
            rdMux = {14'h0, ctrl_ff};
        end else if (inFlog && faultLogActive) begin
            rdMux = flogWord; // R7 R18
        end else if (inSinfo && sysInfoActive) begin
            rdMux = sinfoWord; // R13 R18
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rdData_ff <= 16'h0000;
        end else if (busReq.rdStb) begin
            rdData_ff <= rdMux;
        end else begin
            rdData_ff <= 16'h0000;
        end
    end

    assign rdData = rdData_ff;

endmodule // fpi_process_image

// ---- verification/fpi_process_image_monitor.sv ----
// Purpose: Port checker for the process image
// Assumes: Read data stand in the cycle after the read strobe
// Notes:   Attached to every instance by bind
`timescale 1ns/10ps
module fpi_process_image_monitor #(
    parameter int TICKS_PER_SEC = 200000000
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire fpi_pkg::fpi_req_t busReq,
    input wire logic [15:0] rdData,
    input wire logic [95:0] outStatus,
    input wire logic [63:0] onOffBits,
    input wire logic [63:0] silencePermitBits,
    input wire logic [15:0] virtualRearmBits,
    input wire logic [15:0] actuationCode,
    input wire logic rearmUpdate,
    input wire fpi_pkg::fpi_opstate_t opState,
    input wire logic faultLogActive,
    input wire logic sysInfoActive
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    logic [15:0] statWord;
    logic [15:0] modeCode;
    assign statWord = 16'(outStatus >> {busReq.addr, 4'h0});
    always_comb begin
        case (opState)
            fpi_pkg::FPI_ST_CONFIG: modeCode = 16'h0002;
            fpi_pkg::FPI_ST_LOCKOUT: modeCode = 16'h0004;
            fpi_pkg::FPI_ST_AWAIT_RESET: modeCode = 16'h0041;
            fpi_pkg::FPI_ST_ENTER_CONFIG: modeCode = 16'h0081;
            default: modeCode = 16'h0001;
        endcase
    end
    // ----------------------------------------
    // Bus steps
    // ----------------------------------------
    sequence s_wr(logic [7:0] a);
        busReq.wrStb && busReq.addr == a;
    endsequence
    sequence s_rd(logic [7:0] a);
        busReq.rdStb && busReq.addr == a;
    endsequence
    property p_status;
        busReq.rdStb && busReq.addr <= 8'h05 |=> rdData == $past(statWord);
    endproperty
    a_status: assert property (p_status)
        else $error("status word read wrong");
    property p_rearm;
        s_wr(8'h0c) |=> virtualRearmBits == $past(busReq.wrData) && rearmUpdate;
    endproperty
    a_rearm: assert property (p_rearm)
        else $error("rearm bits not taken");
    property p_code;
        s_wr(8'h0d) |=> actuationCode == $past(busReq.wrData) && rearmUpdate;
    endproperty
    a_code: assert property (p_code)
        else $error("actuation code not taken");
    property p_pulse;
        rearmUpdate |-> $past(busReq.wrStb) && ($past(busReq.addr) inside {8'h0c, 8'h0d});
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("update pulse without rearm write");
    property p_fbRearm;
        s_rd(8'h0e) ##0 $stable(virtualRearmBits) |=> rdData == $past(virtualRearmBits);
    endproperty
    a_fbRearm: assert property (p_fbRearm)
        else $error("rearm feedback wrong");
    property p_fbCode;
        s_rd(8'h0f) ##0 $stable(actuationCode) |=> rdData == $past(actuationCode);
    endproperty
    a_fbCode: assert property (p_fbCode)
        else $error("code feedback wrong");
    property p_ctrl;
        s_wr(8'h10) |=> faultLogActive == $past(busReq.wrData[0])
            && sysInfoActive == $past(busReq.wrData[1]);
    endproperty
    a_ctrl: assert property (p_ctrl)
        else $error("enable bits not taken");
    property p_gate;
        busReq.rdStb && !faultLogActive && (busReq.addr inside {[8'h20:8'hb5]})
            |=> rdData == 16'h0;
    endproperty
    a_gate: assert property (p_gate)
        else $error("disabled fault log readable");
    property p_split;
        $changed(onOffBits | silencePermitBits) |-> $past(busReq.wrStb, 2)
            && ($past(busReq.addr, 2) inside {[8'h08:8'h0b]});
    endproperty
    a_split: assert property (p_split)
        else $error("virtual inputs changed without a write");
    property p_mode;
        s_rd(8'hc2) ##0 sysInfoActive && $stable(opState) |=> rdData == $past(modeCode);
    endproperty
    a_mode: assert property (p_mode)
        else $error("mode code wrong");
endmodule // fpi_process_image_monitor

bind fpi_process_image fpi_process_image_monitor #(.TICKS_PER_SEC(TICKS_PER_SEC)) i_mon (
    .sys_clk, .resetn, .busReq, .rdData, .outStatus, .onOffBits, .silencePermitBits,
    .virtualRearmBits, .actuationCode, .rearmUpdate, .opState, .faultLogActive,
    .sysInfoActive
);

// ---- verification/fpi_master_model.sv ----
// Purpose: Fieldbus master model on the register port
// Assumes: One request per call, strobes one cycle long
// Notes:   Released address and data show the inverse of the last value
`timescale 1ns/10ps
module fpi_master_model (
    input wire logic sys_clk,
    output fpi_pkg::fpi_req_t busReq,
    input wire logic [15:0] rdData
);
    initial busReq = '0;
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        busReq <= {2'b10, a, d};
        @(posedge sys_clk);
        busReq <= {2'b00, ~a, ~d};
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        busReq <= {2'b01, a, 16'h0};
        @(posedge sys_clk);
        busReq <= {2'b00, ~a, 16'hffff};
        #1 d = rdData;
    endtask
endmodule // fpi_master_model

// ---- verification/fpi_process_image_tb.sv ----
// Purpose: Self-checking bench for the process image
// Assumes: One second shortened to TPS cycles
// Notes:   Core side driven here, bus by the master model
`timescale 1ns/10ps
module fpi_process_image_tb;
    localparam int TPS = 10;
    localparam logic [63:0] VIO = 64'h4444_3333_2222_1111;
    localparam logic [63:0] SEL = 64'hff00_00ff_f0f0_0f0f;
    localparam logic [15:0] MODES [5] = '{16'h0001, 16'h0002, 16'h0004, 16'h0041, 16'h0081};
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    fpi_pkg::fpi_req_t busReq;
    logic [15:0] rdData, virtualRearmBits, actuationCode;
    logic [95:0] outStatus = '0;
    logic [63:0] silencePermitSel = '0;
    logic [63:0] onOffBits, silencePermitBits;
    logic rearmUpdate, faultLogActive, sysInfoActive;
    logic faultValid = 1'b0;
    fpi_pkg::fpi_fault_t faultIn = '0;
    fpi_pkg::fpi_opstate_t opState = fpi_pkg::FPI_ST_NORMAL;
    logic [127:0] configName = '0;
    logic [31:0] configCrc = '0;
    int err_total = 0;
    int checks = 0;

    always #2.5 sys_clk = ~sys_clk;

    fpi_master_model i_master (.sys_clk(sys_clk), .busReq(busReq), .rdData(rdData));
    fpi_process_image #(.TICKS_PER_SEC(TPS)) i_dut (
        .sys_clk(sys_clk), .resetn(resetn), .busReq(busReq), .rdData(rdData),
        .outStatus(outStatus), .silencePermitSel(silencePermitSel),
        .onOffBits(onOffBits), .silencePermitBits(silencePermitBits),
        .virtualRearmBits(virtualRearmBits), .actuationCode(actuationCode),
        .rearmUpdate(rearmUpdate), .faultValid(faultValid), .faultIn(faultIn),
        .opState(opState), .configName(configName), .configCrc(configCrc),
        .faultLogActive(faultLogActive), .sysInfoActive(sysInfoActive)
    );

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rdChk(input string n, input logic [7:0] a, input logic [15:0] e);
        logic [15:0] d;
        i_master.rd(a, d);
        chk(n, e, d);
    endtask
    task automatic fault(input logic [15:0] e, input logic [15:0] a, input logic [95:0] nm);
        @(posedge sys_clk);
        faultValid <= 1'b1;
        faultIn <= {nm, e, a};
        @(posedge sys_clk);
        faultValid <= 1'b0;
    endtask
    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_status;
        @(posedge sys_clk);
        outStatus <= 96'h0b0a_0908_0706_0504_0302_0100;
        i_master.wr(8'h00, 16'hffff);
        for (int n = 0; n < 6; n++) begin
            rdChk("status", 8'(n), {8'(2 * n + 1), 8'(2 * n)});
        end
    endtask
    task automatic t_virtual;
        @(posedge sys_clk);
        silencePermitSel <= SEL;
        for (int n = 0; n < 4; n++) begin
            i_master.wr(8'h08 + 8'(n), 16'(VIO >> (16 * n)));
        end
        repeat (2) @(posedge sys_clk);
        #1 chk("onoff", VIO & ~SEL, onOffBits);
        chk("permit", VIO & SEL, silencePermitBits);
        rdChk("vio", 8'h0b, 16'h4444);
    endtask
    task automatic t_rearm;
        i_master.wr(8'h0c, 16'ha5c3);
        #1 chk("pulse", 1'b1, rearmUpdate);
        chk("rearm", 16'ha5c3, virtualRearmBits);
        @(posedge sys_clk);
        #1 chk("pulse", 1'b0, rearmUpdate);
        i_master.wr(8'h0d, 16'h3c5a);
        #1 chk("code", 16'h3c5a, actuationCode);
        rdChk("rearm fb", 8'h0e, 16'ha5c3);
        rdChk("code fb", 8'h0f, 16'h3c5a);
        i_master.wr(8'h0e, 16'hffff);
        rdChk("rearm fb", 8'h0e, 16'ha5c3);
    endtask
    task automatic t_gate;
        i_master.wr(8'h10, 16'h0000);
        rdChk("log off", 8'h20, 16'h0);
        rdChk("info off", 8'hc0, 16'h0);
        rdChk("unmapped", 8'h11, 16'h0);
    endtask
    task automatic t_faults;
        logic [7:0] b;
        logic [15:0] t0, t1;
        i_master.wr(8'h10, 16'h0003);
        #1 chk("enables", 2'b11, {sysInfoActive, faultLogActive});
        for (int k = 1; k <= 10; k++) begin
            fault(16'(k), 16'(k + 3), 96'h4241);
        end
        repeat (28) @(posedge sys_clk);
        fault(16'd11, 16'd14, 96'h43_4241);
        for (int e = 0; e < 10; e++) begin
            b = 8'h20 + 8'(15 * e);
            rdChk("err", b + 8'd10, 16'(11 - e));
            rdChk("index", b + 8'd12, 16'((11 - e) * 100 + 14 - e));
        end
        rdChk("adv", 8'h2b, 16'd14);
        rdChk("name len", 8'h22, 16'd3);
        rdChk("name len hi", 8'h23, 16'd0);
        rdChk("name", 8'h24, 16'h4241);
        rdChk("reserved", 8'h2d, 16'h0);
        i_master.rd(8'h20, t0);
        i_master.rd(8'h2f, t1);
        chk("stamp", 16'd3, 16'(t0 - t1));
    endtask
    task automatic t_sysinfo;
        logic [15:0] s0, s1;
        @(posedge sys_clk);
        configName <= 128'h3147_4643;
        configCrc <= 32'h1234_abcd;
        for (int s = 0; s < 5; s++) begin
            @(posedge sys_clk);
            opState <= fpi_pkg::fpi_opstate_t'(s);
            rdChk("mode", 8'hc2, MODES[s]);
        end
        rdChk("cfg len", 8'hc3, 16'd4);
        rdChk("cfg name", 8'hc5, 16'h4643);
        rdChk("crc lo", 8'hcd, 16'habcd);
        rdChk("crc hi", 8'hce, 16'h1234);
        i_master.wr(8'hdd, 16'hffff);
        rdChk("tail", 8'hdd, 16'h0);
        i_master.rd(8'hc0, s0);
        repeat (18) @(posedge sys_clk);
        i_master.rd(8'hc0, s1);
        chk("seconds", 16'd2, 16'(s1 - s0));
        rdChk("seconds hi", 8'hc1, 16'h0);
    endtask

    initial begin
        repeat (20) @(posedge sys_clk);
        resetn <= 1'b1;
        t_status();
        t_virtual();
        t_rearm();
        t_gate();
        t_faults();
        t_sysinfo();
        end_sim();
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        err_total++;
        end_sim();
    end
endmodule // fpi_process_image_tb
